/* File: hdl/sbt_cfg.svh */
// Constants for the sixteen-bit timer / demodulator: offsets, positions, resets.
// Assumes an 8-bit register port with byte addresses.
`ifndef SBT_CFG_SVH
`define SBT_CFG_SVH

// Register offsets
`define SBT_OFS_SHARED_CTRL   8'h01
`define SBT_OFS_TIMER_CTRL    8'h02
`define SBT_OFS_RELOAD_LO     8'h06
`define SBT_OFS_RELOAD_HI     8'h07
`define SBT_OFS_CAPTURE_LO    8'h08
`define SBT_OFS_CAPTURE_HI    8'h09
`define SBT_OFS_IRQ_STATUS    8'h10
`define SBT_OFS_IRQ_CLEAR     8'h11
`define SBT_OFS_IRQ_ENABLE    8'h12

// Bit positions in the timer control register
`define SBT_BIT_RUN           7
`define SBT_BIT_SINGLE        6
`define SBT_BIT_TIMEOUT       5
`define SBT_BIT_CAP_MASK      2
`define SBT_BIT_TO_MASK       1

// Bit positions in the shared control and interrupt registers
`define SBT_BIT_RISE_FLAG     1
`define SBT_BIT_FALL_FLAG     0
`define SBT_IRQ_TIMEOUT       0
`define SBT_IRQ_CAPTURE       1

// Reset values
`define SBT_RST_SHARED_CTRL   8'h00
`define SBT_RST_TIMER_CTRL    8'h00
`define SBT_RST_RELOAD        16'h0000
`define SBT_RST_CAPTURE       16'h0000
`define SBT_RST_IRQ           2'h0

// Count values
`define SBT_CNT_FULL          16'hFFFF
`define SBT_CNT_TERMINAL      16'h0001
`define SBT_CNT_ZERO          16'h0000

`endif

/* File: hdl/sbt_pkg.sv */
// Types for the sixteen-bit timer / demodulator.
// Assumes the constants header provides all numeric values.
package sbt_pkg;

    typedef enum logic [1:0] {
        SBT_IDLE,
        SBT_RUN_TX,
        SBT_WAIT_EDGE,
        SBT_MEASURE
    } sbt_state_e;

    // Shared timer control register layout
    typedef struct packed {
        logic       demod;
        logic       in_sel;
        logic [1:0] edge_sel;
        logic [1:0] filt;
        logic       rise_flag;
        logic       fall_flag;
    } sbt_shared_s;

    // Sixteen-bit timer control register layout
    typedef struct packed {
        logic       run;
        logic       single;
        logic       timeout;
        logic [1:0] clk_div;
        logic       cap_mask;
        logic       to_mask;
        logic       out_en;
    } sbt_timer_s;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } sbt_req_s;

    // All clocked state of the block
    typedef struct packed {
        sbt_shared_s shared;
        sbt_timer_s  ctrl;
        logic [15:0] reload;
        logic [15:0] capture;
        logic [15:0] count;
        logic [2:0]  pre;
        logic        prev_in;
        logic        out;
        logic [1:0]  irq_sts;
        logic [1:0]  irq_en;
        logic [7:0]  rdata;
        sbt_state_e  st;
    } sbt_regs_s;

endpackage : sbt_pkg

/* File: hdl/sbt_timer.sv */
// Sixteen-bit counter/timer with transmit and edge-measuring demodulation modes.
// Assumes a synchronous 8-bit register port and inputs synchronous to ref_clk_i.
`timescale 1ns/10ps

`include "sbt_cfg.svh"

module sbt_timer #(
    parameter int CNT_W = 16
) (
    // Clock, reset, enable
    input  wire logic       ref_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       ce_i,
    // Register port
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    // Demodulator inputs
    input  wire logic       demod_in_a_i,
    input  wire logic       demod_in_b_i,
    // Outputs
    output logic            counter_output_o,
    output logic            irq_o
);

    if (CNT_W != 16) begin : g_chk
        $error("sbt_timer: CNT_W must be 16");
    end

    sbt_pkg::sbt_regs_s r;
    sbt_pkg::sbt_regs_s next_r;
    sbt_pkg::sbt_req_s  req;

    logic       sig_in;
    logic       edge_rise;
    logic       edge_fall;
    logic       edge_ok;
    logic       tick;
    logic [2:0] div_mask;
    logic       stop_wr;
    logic       ev_to;
    logic       ev_cap;
    logic [1:0] irq_set;
    logic [1:0] irq_clr;
    logic [1:0] next_sts;

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // Input select and edge detection
    always_comb begin
        sig_in    = r.shared.in_sel ? demod_in_b_i : demod_in_a_i;
        edge_rise = sig_in & ~r.prev_in;
        edge_fall = ~sig_in & r.prev_in;
        unique case (r.shared.edge_sel)
            2'b00:   edge_ok = edge_fall;
            2'b01:   edge_ok = edge_rise;
            default: edge_ok = edge_rise | edge_fall;
        endcase
    end

    // Prescaler: one tick every 1, 2, 4 or 8 clocks
    always_comb begin
        unique case (r.ctrl.clk_div)
            2'b00:   div_mask = 3'h0;
            2'b01:   div_mask = 3'h1;
            2'b10:   div_mask = 3'h3;
            default: div_mask = 3'h7;
        endcase
        tick = (r.pre & div_mask) == div_mask;
    end

    // Software stopping the counter this cycle overrides hardware updates
    assign stop_wr = req.wr && (req.addr == `SBT_OFS_TIMER_CTRL)
                     && !req.wdata[`SBT_BIT_RUN];

    // Interrupt status: set wins over clear, per bit
    assign irq_set[`SBT_IRQ_TIMEOUT] = ev_to & r.ctrl.to_mask;
    assign irq_set[`SBT_IRQ_CAPTURE] = ev_cap & r.ctrl.cap_mask;
    assign irq_clr = (req.wr && req.addr == `SBT_OFS_IRQ_CLEAR) ? req.wdata[1:0] : 2'h0;

    for (genvar i = 0; i < 2; i++) begin : g_irq
        assign next_sts[i] = irq_set[i] | (r.irq_sts[i] & ~irq_clr[i]);
    end

    // Next-state logic
    always_comb begin
        next_r         = r;
        next_r.rdata   = 8'h00;
        next_r.prev_in = sig_in;
        ev_to          = 1'b0;
        ev_cap         = 1'b0;

        // Reads
        if (req.rd) begin
            unique case (req.addr)
                `SBT_OFS_SHARED_CTRL: next_r.rdata = r.shared;
                `SBT_OFS_TIMER_CTRL:  next_r.rdata = r.ctrl;
                `SBT_OFS_RELOAD_LO:   next_r.rdata = r.reload[7:0];
                `SBT_OFS_RELOAD_HI:   next_r.rdata = r.reload[15:8];
                `SBT_OFS_CAPTURE_LO:  next_r.rdata = r.capture[7:0];
                `SBT_OFS_CAPTURE_HI:  next_r.rdata = r.capture[15:8];
                `SBT_OFS_IRQ_STATUS:  next_r.rdata = {6'h00, r.irq_sts};
                `SBT_OFS_IRQ_ENABLE:  next_r.rdata = {6'h00, r.irq_en};
                default:              next_r.rdata = 8'h00;
            endcase
        end

        // Writes
        if (req.wr) begin
            unique case (req.addr)
                `SBT_OFS_SHARED_CTRL: begin
                    next_r.shared.demod    = req.wdata[7];
                    next_r.shared.in_sel   = req.wdata[6];
                    next_r.shared.edge_sel = req.wdata[5:4];
                    next_r.shared.filt     = req.wdata[3:2];
                    if (r.shared.demod) begin
                        // Edge flags are write-one-to-clear
                        if (req.wdata[`SBT_BIT_RISE_FLAG]) begin
                            next_r.shared.rise_flag = 1'b0;
                        end
                        if (req.wdata[`SBT_BIT_FALL_FLAG]) begin
                            next_r.shared.fall_flag = 1'b0;
                        end
                    end else begin
                        next_r.shared.rise_flag = req.wdata[`SBT_BIT_RISE_FLAG];
                        next_r.shared.fall_flag = req.wdata[`SBT_BIT_FALL_FLAG];
                    end
                end
                `SBT_OFS_TIMER_CTRL: begin
                    next_r.ctrl.run      = req.wdata[`SBT_BIT_RUN];
                    next_r.ctrl.single   = req.wdata[`SBT_BIT_SINGLE];
                    next_r.ctrl.clk_div  = req.wdata[4:3];
                    next_r.ctrl.cap_mask = req.wdata[`SBT_BIT_CAP_MASK];
                    next_r.ctrl.to_mask  = req.wdata[`SBT_BIT_TO_MASK];
                    next_r.ctrl.out_en   = req.wdata[0];
                    if (req.wdata[`SBT_BIT_TIMEOUT]) begin
                        next_r.ctrl.timeout = 1'b0;
                    end
                    if (req.wdata[`SBT_BIT_RUN] && !r.ctrl.run) begin
                        next_r.pre   = 3'h0;
                        next_r.count = r.reload;
                        next_r.out   = r.shared.fall_flag;
                        next_r.st    = r.shared.demod ? sbt_pkg::SBT_WAIT_EDGE
                                                      : sbt_pkg::SBT_RUN_TX;
                    end
                    if (!req.wdata[`SBT_BIT_RUN]) begin
                        next_r.st = sbt_pkg::SBT_IDLE;
                    end
                end
                `SBT_OFS_RELOAD_LO:  next_r.reload[7:0]  = req.wdata;
                `SBT_OFS_RELOAD_HI:  next_r.reload[15:8] = req.wdata;
                `SBT_OFS_IRQ_ENABLE: next_r.irq_en       = req.wdata[1:0];
                default: ;
            endcase
        end

        // Counting; hardware sets win over software clears above
        if (r.ctrl.run && !stop_wr) begin
            next_r.pre = r.pre + 3'h1;
            unique case (r.st)
                sbt_pkg::SBT_RUN_TX: begin
                    if (tick) begin
                        if (r.count == `SBT_CNT_TERMINAL) begin
                            ev_to               = 1'b1;
                            next_r.ctrl.timeout = 1'b1;
                            next_r.out          = ~r.out;
                            if (r.ctrl.single) begin
                                next_r.count    = `SBT_CNT_ZERO;
                                next_r.ctrl.run = 1'b0;
                                next_r.st       = sbt_pkg::SBT_IDLE;
                            end else begin
                                next_r.count = r.reload;
                            end
                        end else if (r.count == `SBT_CNT_ZERO) begin
                            next_r.count = `SBT_CNT_FULL;
                        end else begin
                            next_r.count = r.count - 16'h0001;
                        end
                    end
                end
                sbt_pkg::SBT_WAIT_EDGE: begin
                    if (edge_ok) begin
                        ev_cap         = 1'b1;
                        next_r.capture = ~r.count;
                        next_r.count   = `SBT_CNT_FULL;
                        next_r.pre     = 3'h0;
                        next_r.st      = sbt_pkg::SBT_MEASURE;
                    end
                end
                sbt_pkg::SBT_MEASURE: begin
                    if (edge_ok && !r.ctrl.single) begin
                        ev_cap         = 1'b1;
                        next_r.capture = ~r.count;
                        next_r.count   = `SBT_CNT_FULL;
                        next_r.pre     = 3'h0;
                    end else if (tick) begin
                        if (r.count == `SBT_CNT_TERMINAL) begin
                            ev_to               = 1'b1;
                            next_r.ctrl.timeout = 1'b1;
                            next_r.count        = `SBT_CNT_FULL;
                        end else if (r.count == `SBT_CNT_ZERO) begin
                            next_r.count = `SBT_CNT_FULL;
                        end else begin
                            next_r.count = r.count - 16'h0001;
                        end
                    end
                end
                sbt_pkg::SBT_IDLE: ;
            endcase
            if (ev_cap) begin
                if (edge_rise) begin
                    next_r.shared.rise_flag = 1'b1;
                end
                if (edge_fall) begin
                    next_r.shared.fall_flag = 1'b1;
                end
            end
        end

        next_r.irq_sts = next_sts;
    end

    // State registers
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r.shared  <= `SBT_RST_SHARED_CTRL;
            r.ctrl    <= `SBT_RST_TIMER_CTRL;
            r.reload  <= `SBT_RST_RELOAD;
            r.capture <= `SBT_RST_CAPTURE;
            r.count   <= `SBT_CNT_ZERO;
            r.pre     <= 3'h0;
            r.prev_in <= 1'b0;
            r.out     <= 1'b0;
            r.irq_sts <= `SBT_RST_IRQ;
            r.irq_en  <= `SBT_RST_IRQ;
            r.rdata   <= 8'h00;
            r.st      <= sbt_pkg::SBT_IDLE;
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    // Outputs
    assign rdata_o          = r.rdata;
    assign counter_output_o = r.ctrl.out_en & r.out;
    assign irq_o            = |(r.irq_sts & r.irq_en);

endmodule : sbt_timer

/* File: bench/sbt_timer_assertions.sv */
// Concurrent checks on the timer's register port and pins.
// Assumes it is bound to sbt_timer and sees only its ports.
`timescale 1ns/10ps

module sbt_timer_assertions (
    // Clock, reset, enable
    input wire logic       ref_clk_i,
    input wire logic       resetn_i,
    input wire logic       ce_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    // Pins
    input wire logic       demod_in_a_i,
    input wire logic       demod_in_b_i,
    input wire logic       counter_output_o,
    input wire logic       irq_o
);
    logic [7:0] ctl;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] rl;
    logic [1:0] en;
    logic       mode;
    logic       ran;
    logic       rq;
    assign rq = rd_i & ce_i;
    assign rl = addr_i[0] ? hi : lo;
    // Shadow of what software wrote
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {ctl, lo, hi, en, mode, ran} <= '0;
        end else if (wr_i && ce_i) begin
            if (addr_i == 8'h02) ctl <= wdata_i;
            if (addr_i == 8'h06) lo <= wdata_i;
            if (addr_i == 8'h07) hi <= wdata_i;
            if (addr_i == 8'h12) en <= wdata_i[1:0];
            if (addr_i == 8'h01) mode <= wdata_i[7];
            if (addr_i == 8'h02 && wdata_i[7]) ran <= 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    rd_idle_a: assert property (ce_i && !rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    wo_read_a: assert property (rq && addr_i == 8'h11 |=> rdata_o == 8'h00)
        else $error("clear register read not zero");
    mode_read_a: assert property (rq && addr_i == 8'h01 |=> rdata_o[7] == $past(mode))
        else $error("mode bit read back wrong");
    ctrl_read_a: assert property (rq && addr_i == 8'h02 |=> rdata_o[4:0] == $past(ctl[4:0]))
        else $error("control bits read back wrong");
    reload_read_a: assert property (rq && addr_i[7:1] == 7'h03 |=> rdata_o == $past(rl))
        else $error("reload byte read back wrong");
    idle_out_a: assert property (!ran |-> !counter_output_o)
        else $error("output moved before the counter ran");
    irq_gate_a: assert property ((en == 2'b00) [*2] |-> !irq_o)
        else $error("interrupt high with all sources disabled");
    ce_hold_a: assert property (!ce_i |=> $stable(counter_output_o) && $stable(irq_o))
        else $error("outputs moved with clock enable low");
    single_hold_a: assert property (!mode && ctl[6] && !$past(wr_i) && $changed(counter_output_o)
        |=> ($past(wr_i) || $stable(counter_output_o)) [*8])
        else $error("output moved after single pass end");

    toggle_c: cover property (!mode && $changed(counter_output_o));
    irq_c: cover property ($rose(irq_o));
    cap_c: cover property (rq && addr_i == 8'h08);
endmodule : sbt_timer_assertions

/* File: bench/sbt_carrier_model.sv */
// Far-side carrier source for the two demodulator pins.
// Assumes the bench sets the line level and which pin carries it.
`timescale 1ns/10ps

module sbt_carrier_model (
    // From the bench
    input  wire logic ref_clk_i,
    input  wire logic level_i,
    input  wire logic sel_i,
    // Demodulator pins
    output logic      pin_a_o,
    output logic      pin_b_o
);
    logic noise = 1'b0;
    // The idle pin chatters so that a wrong input choice shows
    always_ff @(posedge ref_clk_i) noise <= ~noise;
    assign pin_a_o = sel_i ? noise : level_i;
    assign pin_b_o = sel_i ? level_i : noise;
endmodule : sbt_carrier_model

/* File: bench/testbench.sv */
// Self-checking bench for the sixteen-bit timer / demodulator.
// Assumes the design, its checker and the carrier model are compiled first.
`timescale 1ns/10ps

bind sbt_timer sbt_timer_assertions sbt_timer_assertions_inst (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .demod_in_a_i(demod_in_a_i), .demod_in_b_i(demod_in_b_i),
    .counter_output_o(counter_output_o), .irq_o(irq_o));

module testbench;
    logic        ref_clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        ce_i = 1'b1;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    logic [7:0]  wdata_i = 8'h00;
    logic [7:0]  rdata_o;
    logic        level = 1'b0;
    logic        sel = 1'b0;
    logic        pin_a;
    logic        pin_b;
    logic        cnt_out;
    logic        irq_o;
    logic        rd_q = 1'b0;
    logic [15:0] ent;
    logic [15:0] expq[$];
    logic [31:0] seed = 32'h447e_5faf;
    int          fail_count = 0;
    int          compares = 0;
    int          cyc = 0;
    int          n;
    int          k;
    int          p;

    sbt_timer sbt_timer_inst (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .demod_in_a_i(pin_a), .demod_in_b_i(pin_b), .counter_output_o(cnt_out),
        .irq_o(irq_o));
    sbt_carrier_model sbt_carrier_model_inst (.ref_clk_i(ref_clk_i), .level_i(level),
        .sel_i(sel), .pin_a_o(pin_a), .pin_b_o(pin_b));

    initial forever #2 ref_clk_i = ~ref_clk_i;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic close_out();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] s);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : check

    task automatic tick(input int c);
        repeat (c) @(posedge ref_clk_i);
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        tick(1);
        wr_i <= 1'b0;
        tick(1);
    endtask : wr

    // Read whose expected value the monitor compares one cycle later
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expq.push_back({a, e});
        addr_i <= a;
        rd_i <= 1'b1;
        tick(1);
        rd_i <= 1'b0;
        tick(1);
    endtask : rd

    // Cycles until the counter output next changes, at most 99
    task automatic gap(output int c);
        logic v;
        v = cnt_out;
        c = 0;
        do begin
            tick(1);
            c++;
        end while (cnt_out === v && c < 99);
    endtask : gap

    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        rd_q <= rd_i & ce_i;
        if (rd_q) begin
            ent = expq.pop_front();
            check($sformatf("reg %h", ent[15:8]), ent[7:0], rdata_o);
        end
        if (cyc == 20000) begin
            fail_count++;
            close_out();
        end
    end

    initial begin
        tick(12);
        resetn_i <= 1'b1;
        tick(1);
        rd(8'h01, 8'h00);
        rd(8'h02, 8'h00);
        wr(8'h08, 8'h5a);
        rd(8'h08, 8'h00);
        rd(8'h11, 8'h00);
        rd(8'h20, 8'h00);
        ce_i <= 1'b0;
        tick(3);
        ce_i <= 1'b1;
        $display("test reset done");
        seed = lfsr(seed);
        n = 2 + seed[2:0];
        wr(8'h06, n[7:0]);
        wr(8'h07, 8'h00);
        rd(8'h06, n[7:0]);
        wr(8'h02, 8'h81);
        gap(p);
        gap(p);
        check("period", n[7:0], p[7:0]);
        rd(8'h02, 8'ha1);
        wr(8'h02, 8'h01);
        wr(8'h02, 8'h21);
        rd(8'h02, 8'h01);
        gap(p);
        check("halted", 8'h63, p[7:0]);
        wr(8'h12, 8'h03);
        wr(8'h02, 8'hc3);
        tick(20);
        rd(8'h02, 8'h63);
        rd(8'h10, 8'h01);
        check("irq", 8'h01, {7'h00, irq_o});
        wr(8'h11, 8'h01);
        tick(1);
        check("irq", 8'h00, {7'h00, irq_o});
        wr(8'h02, 8'h20);
        wr(8'h02, 8'h80);
        tick(20);
        wr(8'h02, 8'h00);
        rd(8'h02, 8'h20);
        rd(8'h10, 8'h00);
        wr(8'h02, 8'h20);
        wr(8'h06, 8'h00);
        wr(8'h02, 8'h82);
        tick(30);
        rd(8'h02, 8'h82);
        rd(8'h10, 8'h00);
        wr(8'h02, 8'h00);
        $display("test transmit done");
        wr(8'h06, 8'hff);
        wr(8'h07, 8'hff);
        wr(8'h01, 8'hb0);
        wr(8'h02, 8'h84);
        seed = lfsr(seed);
        k = 10 + seed[12:8];
        level <= 1'b1;
        tick(k);
        level <= 1'b0;
        tick(4);
        rd(8'h08, k[7:0] - 8'h01);
        rd(8'h09, 8'h00);
        rd(8'h01, 8'hb3);
        rd(8'h10, 8'h02);
        wr(8'h01, 8'hb2);
        rd(8'h01, 8'hb1);
        $display("test demodulation done");
        wr(8'h02, 8'h04);
        wr(8'h11, 8'h03);
        sel <= 1'b1;
        wr(8'h01, 8'hc1);
        rd(8'h01, 8'hc0);
        wr(8'h02, 8'hc4);
        repeat (2) begin
            level <= 1'b1;
            tick(5);
            level <= 1'b0;
            tick(5);
        end
        rd(8'h08, 8'h00);
        rd(8'h09, 8'h00);
        rd(8'h01, 8'hc1);
        $display("test ignore done");
        close_out();
    end
endmodule : testbench
